// >>> src/cpsc_pkg.sv
// Shared constants for the CAN power-save control block
package cpsc_pkg;

  // Bus geometry
  localparam int ADDR_W = 10;                      // Byte address width
  localparam int DATA_W = 32;                      // Avalon data width

  // Register byte offsets
  localparam logic [9:0] OFS_CTRL     = 10'h000;   // module_control_reg
  localparam logic [9:0] OFS_IRQ_STAT = 10'h004;   // irq_status_reg
  localparam logic [9:0] OFS_IRQ_EN   = 10'h008;   // irq_enable_reg
  localparam logic [9:0] OFS_LIPT     = 10'h00C;   // last_in_pointer_reg
  localparam logic [9:0] OFS_RHIST    = 10'h010;   // receive_history_reg
  localparam logic [9:0] OFS_LOPT     = 10'h014;   // last_out_pointer_reg
  localparam logic [9:0] OFS_THIST    = 10'h018;   // transmit_history_reg
  localparam logic [9:0] OFS_BUF_BASE = 10'h200;   // buffer_config_reg, buffer 0
  localparam int         NUM_BUF      = 32;        // Message buffers

  // module_control_reg fields
  localparam int CTRL_PS_LO    = 0;                // power_save_field_lo
  localparam int CTRL_PS_HI    = 1;                // power_save_field_hi
  localparam int CTRL_MODE_LSB = 2;                // Operating mode, 3 bits
  localparam int CTRL_SLP_PEND = 5;                // Sleep request held
  localparam int CTRL_INI_PEND = 6;                // Init request held

  // Power-save field codes
  localparam logic [1:0] PS_NONE  = 2'h0;          // No power save / release
  localparam logic [1:0] PS_SLEEP = 2'h1;          // Sleep request / status
  localparam logic [1:0] PS_STOP  = 2'h3;          // Stop request / status

  // Operating mode codes
  localparam logic [2:0] MODE_INIT    = 3'h0;
  localparam logic [2:0] MODE_NORMAL  = 3'h1;
  localparam logic [2:0] MODE_ABT     = 3'h2;
  localparam logic [2:0] MODE_RX_ONLY = 3'h3;
  localparam logic [2:0] MODE_SHOT    = 3'h4;
  localparam logic [2:0] MODE_SELF    = 3'h5;
  localparam logic [2:0] MODE_RESET   = MODE_INIT; // Mode after reset

  // Status and enable bit position of the wake-up source
  localparam int WAKE_BIT = 5;

  // buffer_config_reg fields
  localparam int CFG_REMOTE = 0;                   // remote_frame_select
  localparam int CFG_TX     = 1;                   // Buffer is a transmit buffer

  // Rejoin after wake-up: consecutive recessive bits
  localparam logic [3:0] REJOIN_BITS = 4'hB;

  // Power state
  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_STOP} cpsc_state_t;

endpackage

// >>> src/cpsc_power_save_control.sv
// Behaviour
// - Transmit buffer with select bit sends remote
// - Writing 01B to field requests sleep
// - Sleep request in init mode ignored
// - Sleep held until bus idle, reads 00B
// - Stuck bus keeps pending; stop-to-sleep unconditional
// - Sleep needs no pending transmission request
// - Simultaneous init and sleep: init wins
// - Init cancels pending or later sleep
// - No transmission in sleep or stop
// - Clock stopped in sleep, edge detect alive
// - Sleep/stop: only field writable, reads limited
// - Init request in sleep ignored
// - Sleep left by 00B write or edge
// - Waking frame is not received
// - Release restores mode, 00B; bus release sets wake flag
// - Rejoin bus after 11 recessive bits
// - Stop accepted only from sleep
// - Stop left only by 01B write
// - Other requests from stop ignored
// - Bus edge before stop request blocks stop
// - Gated clock: flag set, release deferred
// - Clock restored: leave sleep at once
`timescale 1ns/1ps
module cpsc_power_save_control
  import cpsc_pkg::*;
(
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                resetn,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0]   avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [DATA_W-1:0]   avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic      [DATA_W-1:0]   avs_readdata,
  output logic                     avs_waitrequest,
  // CAN bus side
  input  wire logic                bus_receive_pin,
  // Protocol engine status, same clock
  input  wire logic                bus_idle,
  input  wire logic                tx_pending,
  input  wire logic                bit_sample_strobe,
  input  wire logic [4:0]          tx_buf_idx,
  input  wire logic [7:0]          last_in_ptr,
  input  wire logic [7:0]          rx_hist,
  input  wire logic [7:0]          last_out_ptr,
  input  wire logic [7:0]          tx_hist,
  // System clock control, same clock
  input  wire logic                module_clk_en,
  // Control outputs
  output logic      [2:0]          op_mode,
  output logic                     tx_inhibit,
  output logic                     rx_discard,
  output logic                     clk_stop_req,
  output logic                     tx_remote_frame,
  output logic                     wakeup_irq_line
);

  // Buffer region decode, used by read and write paths
  function automatic logic is_buf(input logic [ADDR_W-1:0] a);
    is_buf = (a[9] == 1'b1) && (a[8:7] == 2'h0) && (a[1:0] == 2'h0);
  endfunction

  cpsc_state_t state;                    // Power state
  logic        sleep_pending;            // Sleep request held
  logic        init_pending;             // Init request held
  logic        wake_hold;                // Bus edge seen, release owed
  logic        wakeup_status_flag;       // Sticky wake-up status
  logic        wakeup_irq_enable;        // Wake-up interrupt enable
  logic        rx_s1;                    // Pin synchroniser stage 1
  logic        rx_s2;                    // Pin synchroniser stage 2
  logic        rx_prev;                  // Previous synchronised level
  logic        rejoin_wait;              // Waiting for idle bus
  logic [3:0]  rec_cnt;                  // Consecutive recessive bits
  logic [1:0]  buffer_config_reg [NUM_BUF]; // Per-buffer configuration
  logic        ack;                      // Access completes this cycle

  logic        rx_fall;                  // Recessive to dominant edge
  logic        wake_evt;                 // Edge while asleep
  logic        wr_go;                    // Write takes effect
  logic        wr_ctrl;                  // Write to control register
  logic [1:0]  ps_wr;                    // Written power-save value
  logic [2:0]  mode_wr;                  // Written operating mode
  logic        init_req;                 // Write asks for init mode
  logic        awake;                    // Not in sleep or stop
  logic        sleep_go;                 // Sleep entry this cycle
  logic        wake_release;             // Bus-driven release this cycle
  logic [1:0]  ps_read;                  // Field as software sees it
  logic [DATA_W-1:0] next_readdata;      // Read mux

  assign awake = (state == ST_RUN);

  // One wait state per access; response always defined
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read || avs_write) && !ack;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack;

  // Write decode, only the low byte carries fields
  assign wr_go   = avs_write && ack && avs_byteenable[0];
  assign wr_ctrl = wr_go && (avs_address == OFS_CTRL);
  assign ps_wr   = avs_writedata[CTRL_PS_HI:CTRL_PS_LO];
  assign mode_wr = avs_writedata[CTRL_MODE_LSB+2:CTRL_MODE_LSB];
  assign init_req = wr_ctrl && awake && (mode_wr == MODE_INIT) && (op_mode != MODE_INIT);

  // Pin synchroniser; stage 1 feeds stage 2 only
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_s1   <= 1'b1;
      rx_s2   <= 1'b1;
      rx_prev <= 1'b1;
    end else begin
      rx_s1   <= bus_receive_pin;
      rx_s2   <= rx_s1;
      rx_prev <= rx_s2;
    end
  end

  // Edge detect runs on the free clock
  assign rx_fall  = rx_prev && !rx_s2;
  assign wake_evt = (state == ST_SLEEP) && rx_fall;

  assign wake_release = (state == ST_SLEEP) && (wake_evt || wake_hold) && module_clk_en;

  // Entry needs idle bus and no request
  assign sleep_go = awake && sleep_pending && bus_idle && !tx_pending;

  // Operating mode; kept through sleep so release returns to it
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      op_mode <= MODE_RESET;
    end else if (init_pending && bus_idle && awake) begin
      op_mode <= MODE_INIT;
    end else if (wr_ctrl && awake && op_mode == MODE_INIT && mode_wr != MODE_INIT
                 && mode_wr <= MODE_SELF) begin
      // Leaving init only; illegal codes dropped
      op_mode <= mode_wr;
    end
  end

  // Init request waits for bus idle; leaving init does not
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      init_pending <= 1'b0;
    end else if (init_req) begin
      init_pending <= 1'b1;
    end else if (bus_idle) begin
      init_pending <= 1'b0;
    end
  end

  // Sleep request bookkeeping
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sleep_pending <= 1'b0;
    end else if (init_req || init_pending) begin
      sleep_pending <= 1'b0;
    end else if (sleep_go) begin
      sleep_pending <= 1'b0;
    end else if (wr_ctrl && awake) begin
      if (ps_wr == PS_SLEEP) begin
        sleep_pending <= (op_mode != MODE_INIT);
      end else if (ps_wr == PS_NONE) begin
        // Withdrawn before it took effect
        sleep_pending <= 1'b0;
      end
    end
  end

  // Power state machine
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_RUN;
    end else begin
      unique case (state)
        ST_RUN: begin
          if (sleep_go) begin
            state <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (wake_release) begin
            state <= ST_RUN;
          end else if (wr_ctrl && ps_wr == PS_NONE) begin
            state <= ST_RUN;
          end else if (wr_ctrl && ps_wr == PS_STOP && !wake_evt && !wake_hold) begin
            state <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (wr_ctrl && ps_wr == PS_SLEEP) begin
            state <= ST_SLEEP;
          end
        end
      endcase
    end
  end

  // Edge owed a release while the module clock is off
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wake_hold <= 1'b0;
    end else if (state != ST_SLEEP || wake_release) begin
      wake_hold <= 1'b0;
    end else if (wake_evt) begin
      wake_hold <= 1'b1;
    end
  end

  // Wake-up status: set wins over a software clear
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wakeup_status_flag <= 1'b0;
    end else if (wake_evt) begin
      wakeup_status_flag <= 1'b1;
    end else if (wr_go && awake && avs_address == OFS_IRQ_STAT
                 && !avs_writedata[WAKE_BIT]) begin
      wakeup_status_flag <= 1'b0;
    end
  end

  // Wake-up interrupt enable
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wakeup_irq_enable <= 1'b0;
    end else if (wr_go && awake && avs_address == OFS_IRQ_EN) begin
      wakeup_irq_enable <= avs_writedata[WAKE_BIT];
    end
  end

  assign wakeup_irq_line = wakeup_status_flag && wakeup_irq_enable;

  // Rejoin watch after any release from sleep
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rejoin_wait <= 1'b0;
      rec_cnt     <= 4'h0;
    end else if (state == ST_SLEEP && (wake_release || (wr_ctrl && ps_wr == PS_NONE))) begin
      rejoin_wait <= 1'b1;
      rec_cnt     <= 4'h0;
    end else if (rejoin_wait && bit_sample_strobe) begin
      // Eleven recessive bits in a row
      if (!rx_s2) begin
        rec_cnt <= 4'h0;
      end else if (rec_cnt == REJOIN_BITS - 4'h1) begin
        rejoin_wait <= 1'b0;
        rec_cnt     <= 4'h0;
      end else begin
        rec_cnt <= rec_cnt + 4'h1;
      end
    end
  end

  // No transmission while asleep or rejoining
  assign tx_inhibit   = !awake || rejoin_wait;
  assign rx_discard   = !awake || rejoin_wait;
  // Ask the clock unit to stop
  assign clk_stop_req = !awake;

  // Buffer configuration storage; locked while asleep
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_BUF; i++) begin
        buffer_config_reg[i] <= 2'h0;
      end
    end else if (wr_go && awake && is_buf(avs_address)) begin
      buffer_config_reg[avs_address[6:2]] <= avs_writedata[1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_remote_frame <= 1'b0;
    end else begin
      tx_remote_frame <= buffer_config_reg[tx_buf_idx][CFG_REMOTE]
                         && buffer_config_reg[tx_buf_idx][CFG_TX];
    end
  end

  always_comb begin
    unique case (state)
      ST_SLEEP: ps_read = PS_SLEEP;
      ST_STOP:  ps_read = PS_STOP;
      default:  ps_read = PS_NONE;
    endcase
  end

  // Read mux; hidden registers read as zero when asleep
  always_comb begin
    next_readdata = '0;
    if (avs_address == OFS_CTRL) begin
      next_readdata[CTRL_PS_HI:CTRL_PS_LO]          = ps_read;
      next_readdata[CTRL_MODE_LSB+2:CTRL_MODE_LSB]  = op_mode;
      next_readdata[CTRL_SLP_PEND]                  = sleep_pending;
      next_readdata[CTRL_INI_PEND]                  = init_pending;
    end else if (avs_address == OFS_IRQ_STAT) begin
      next_readdata[WAKE_BIT] = wakeup_status_flag;
    end else if (avs_address == OFS_IRQ_EN) begin
      next_readdata[WAKE_BIT] = wakeup_irq_enable;
    end else if (awake) begin
      if (avs_address == OFS_LIPT) begin
        next_readdata[7:0] = last_in_ptr;
      end else if (avs_address == OFS_RHIST) begin
        next_readdata[7:0] = rx_hist;
      end else if (avs_address == OFS_LOPT) begin
        next_readdata[7:0] = last_out_ptr;
      end else if (avs_address == OFS_THIST) begin
        next_readdata[7:0] = tx_hist;
      end else if (is_buf(avs_address)) begin
        next_readdata[1:0] = buffer_config_reg[avs_address[6:2]];
      end
    end
  end

  // Read data captured on the same edge that waitrequest falls
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= '0;
    end else if (avs_read && !ack) begin
      avs_readdata <= next_readdata;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_init_no_sleep: assert property (
    (awake && op_mode == MODE_INIT && wr_ctrl && ps_wr == PS_SLEEP) |=> !sleep_pending [*2])
    else $error("sleep request taken in init mode");

  a_sleep_entry_gate: assert property (
    (awake ##1 state == ST_SLEEP) |-> $past(bus_idle) && !$past(tx_pending))
    else $error("sleep entered with busy bus or pending request");

  a_init_over_sleep: assert property (
    init_pending |-> !sleep_pending)
    else $error("sleep request survived init request");

  a_tx_blocked: assert property (
    (state != ST_RUN) |-> tx_inhibit && rx_discard)
    else $error("transmit allowed while asleep");

  a_wake_sets_flag: assert property (
    wake_evt |=> wakeup_status_flag ##1 (wakeup_status_flag || ack))
    else $error("bus wake did not set status flag");

  a_rejoin_count: assert property (
    $fell(rejoin_wait) |-> $past(rec_cnt) == 4'hA && $past(rx_s2) && $past(bit_sample_strobe))
    else $error("rejoin before eleven recessive bits");

  a_stop_from_sleep: assert property (
    $rose(state == ST_STOP) |-> $past(state) == ST_SLEEP && $past(ps_wr) == PS_STOP)
    else $error("stop entered from wrong mode");

  a_stop_holds: assert property (
    (state == ST_STOP && !(wr_ctrl && ps_wr == PS_SLEEP)) |=> state == ST_STOP)
    else $error("stop left without 01B write");

  a_gated_sleep: assert property (
    (state == ST_SLEEP && !module_clk_en && !wr_ctrl) |=> state == ST_SLEEP)
    else $error("sleep released with clock gated");

  a_field_mode: assert property (
    (state == ST_STOP ##1 state == ST_STOP) |-> ps_read == PS_STOP && clk_stop_req)
    else $error("field disagrees with power state");

  c_bus_wake: cover property (state == ST_SLEEP ##1 state == ST_RUN && rejoin_wait);
  c_stop_round: cover property (state == ST_STOP ##[1:50] state == ST_SLEEP);
  c_held_sleep: cover property (sleep_pending && !bus_idle ##[1:20] state == ST_SLEEP);

endmodule

// >>> sim/cpsc_bus_model.sv
`timescale 1ns/1ps
// Far side: other nodes on the bus, seen through the transceiver
module cpsc_bus_model (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic resetn,
  // Scenario controls
  input  wire logic hold_dom,
  input  wire logic busy,
  // Bus view towards the controller
  output logic      bus_receive_pin,
  output logic      bus_idle,
  output logic      bit_sample_strobe
);
  logic [1:0] div; // Bit time of four clocks

  // Bit timing divider, short so rejoin counts stay quick
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      div <= 2'h0;
    end else begin
      div <= div + 2'h1;
    end
  end

  assign bit_sample_strobe = (div == 2'h3);
  // Wired bus pulls to recessive unless a node drives dominant
  assign bus_receive_pin = ~hold_dom;
  // idle only while recessive and no frame
  assign bus_idle = ~busy & ~hold_dom;
endmodule

// >>> sim/can_power_save_control_test.sv
`timescale 1ns/1ps
module can_power_save_control_test
  import cpsc_pkg::*;
;
  // Clock, reset and bus master
  logic              ref_clk = 1'h0;
  logic              resetn = 1'h0;
  logic [ADDR_W-1:0] avs_address = 10'h000;
  logic              avs_read = 1'h0;
  logic              avs_write = 1'h0;
  logic [DATA_W-1:0] avs_writedata = 32'h0;
  logic [DATA_W-1:0] avs_readdata;
  logic              avs_waitrequest;
  // Engine status and scenario controls
  logic              tx_pending = 1'h0;
  logic [4:0]        tx_buf_idx = 5'h00;
  logic              module_clk_en = 1'h1;
  logic              hold_dom = 1'h0;
  logic              busy = 1'h0;
  logic              bus_receive_pin;
  logic              bus_idle;
  logic              bit_sample_strobe;
  // Controller outputs
  logic [2:0]        op_mode;
  logic              tx_inhibit;
  logic              rx_discard;
  logic              clk_stop_req;
  logic              tx_remote_frame;
  logic              wakeup_irq_line;
  // Score
  int                err_total = 0;
  int                checked = 0;

  // 20 MHz clock
  always #25 ref_clk = ~ref_clk;

  cpsc_power_save_control cpsc_power_save_control_i (
    .ref_clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .bus_receive_pin,
    .bus_idle, .tx_pending, .bit_sample_strobe, .tx_buf_idx,
    .last_in_ptr(8'h5A), .rx_hist(8'h3C), .last_out_ptr(8'hA5), .tx_hist(8'hC3),
    .module_clk_en, .op_mode, .tx_inhibit, .rx_discard, .clk_stop_req,
    .tx_remote_frame, .wakeup_irq_line);

  cpsc_bus_model cpsc_bus_model_i (
    .ref_clk, .resetn, .hold_dom, .busy, .bus_receive_pin, .bus_idle,
    .bit_sample_strobe);

  // Verdict, reached from the sequence or the watchdog
  task automatic complete_run;
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One access, held until waitrequest low is sampled at an edge
  task automatic acc(input logic rw, input logic [9:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~rw;
    avs_write <= rw;
    #1;
    // Bounded wait, a hung slave counts as a mismatch
    while (avs_waitrequest !== 1'h0 && n < 20) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n == 20) err_total++;
    @(posedge ref_clk);
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'h1, a, d, q);
  endtask

  task automatic rc(input logic [9:0] a, input logic [31:0] e);
    logic [31:0] q;
    acc(1'h0, a, 32'h0, q);
    chk(q, e);
  endtask

  // One clock of dominant level on the bus
  task automatic pulse;
    @(posedge ref_clk);
    hold_dom <= 1'h1;
    @(posedge ref_clk);
    hold_dom <= 1'h0;
  endtask

  // Count bit samples until frames are taken again
  task automatic rejoin(input int lo);
    int n;
    int k;
    n = 0;
    k = 0;
    #1;
    while (rx_discard !== 1'h0 && k < 400) begin
      // Bits only count once the controller is awake again
      if (bit_sample_strobe === 1'h1 && clk_stop_req === 1'h0) n++;
      k++;
      @(posedge ref_clk);
      #1;
    end
    // Bus stays recessive, so the run is exactly the rule's length
    chk(32'(n), 32'(lo));
  endtask

  // Watchdog, far beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    complete_run;
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    resetn <= 1'h1;
    // Init mode refuses both power-save requests
    rc(OFS_CTRL, 32'h00);
    wr(OFS_CTRL, 32'h01);
    rc(OFS_CTRL, 32'h00);
    wr(OFS_CTRL, 32'h03);
    rc(OFS_CTRL, 32'h00);
    // Normal mode, remote frame selection per buffer
    wr(OFS_CTRL, 32'h04);
    wr(OFS_BUF_BASE + 10'h00C, 32'h3);
    wr(OFS_BUF_BASE + 10'h010, 32'h1);
    tx_buf_idx <= 5'h03;
    repeat (3) @(posedge ref_clk);
    chk(32'(tx_remote_frame), 32'h1);
    tx_buf_idx <= 5'h04;
    repeat (3) @(posedge ref_clk);
    chk(32'(tx_remote_frame), 32'h0);
    rc(OFS_LIPT, 32'h5A);
    wr(OFS_CTRL, 32'h07);
    rc(OFS_CTRL, 32'h04);
    // Init request against sleep request on a busy bus
    busy <= 1'h1;
    wr(OFS_CTRL, 32'h01);
    rc(OFS_CTRL, 32'h44);
    wr(OFS_CTRL, 32'h05);
    rc(OFS_CTRL, 32'h44);
    busy <= 1'h0;
    rc(OFS_CTRL, 32'h00);
    wr(OFS_CTRL, 32'h04);
    // Sleep held by a busy bus, then by a pending transmission
    busy <= 1'h1;
    tx_pending <= 1'h1;
    wr(OFS_CTRL, 32'h05);
    rc(OFS_CTRL, 32'h24);
    busy <= 1'h0;
    rc(OFS_CTRL, 32'h24);
    tx_pending <= 1'h0;
    rc(OFS_CTRL, 32'h05);
    tx_pending <= 1'h1;
    repeat (2) @(posedge ref_clk);
    chk(32'(tx_inhibit), 32'h1);
    chk(32'(clk_stop_req), 32'h1);
    // Access limits while asleep
    wr(OFS_IRQ_EN, 32'h20);
    rc(OFS_IRQ_EN, 32'h00);
    rc(OFS_LIPT, 32'h00);
    rc(OFS_BUF_BASE + 10'h00C, 32'h00);
    wr(OFS_CTRL, 32'h01);
    rc(OFS_CTRL, 32'h05);
    // Stop: entered from sleep, deaf to bus and other requests
    wr(OFS_CTRL, 32'h07);
    rc(OFS_CTRL, 32'h07);
    chk(32'(tx_inhibit), 32'h1);
    pulse();
    rc(OFS_CTRL, 32'h07);
    wr(OFS_CTRL, 32'h00);
    rc(OFS_CTRL, 32'h07);
    // Stop to sleep with the bus stuck dominant
    hold_dom <= 1'h1;
    repeat (4) @(posedge ref_clk);
    wr(OFS_CTRL, 32'h05);
    rc(OFS_CTRL, 32'h05);
    hold_dom <= 1'h0;
    repeat (4) @(posedge ref_clk);
    // Software release
    wr(OFS_CTRL, 32'h00);
    rejoin(11);
    rc(OFS_CTRL, 32'h04);
    rc(OFS_IRQ_STAT, 32'h00);
    // Bus wake-up
    tx_pending <= 1'h0;
    wr(OFS_CTRL, 32'h05);
    rc(OFS_CTRL, 32'h05);
    pulse();
    rejoin(11);
    rc(OFS_CTRL, 32'h04);
    rc(OFS_IRQ_STAT, 32'h20);
    wr(OFS_IRQ_EN, 32'h20);
    // Look mid-cycle, after the enable has settled
    @(negedge ref_clk);
    chk(32'(wakeup_irq_line), 32'h1);
    wr(OFS_IRQ_STAT, 32'h00);
    @(negedge ref_clk);
    chk(32'(wakeup_irq_line), 32'h0);
    // Bus edge racing a stop request; one dominant clock only
    wr(OFS_CTRL, 32'h05);
    hold_dom <= 1'h1;
    fork
      wr(OFS_CTRL, 32'h07);
      begin
        @(posedge ref_clk);
        hold_dom <= 1'h0;
      end
    join
    rejoin(11);
    rc(OFS_CTRL, 32'h04);
    // Wake-up with the module clock gated off, status cleared first
    wr(OFS_IRQ_STAT, 32'h00);
    wr(OFS_CTRL, 32'h05);
    module_clk_en <= 1'h0;
    pulse();
    repeat (4) @(posedge ref_clk);
    rc(OFS_IRQ_STAT, 32'h20);
    rc(OFS_CTRL, 32'h05);
    module_clk_en <= 1'h1;
    rc(OFS_CTRL, 32'h04);
    chk(32'(op_mode), 32'h1);
    complete_run();
  end
endmodule
